// ---- rtl/s2c_pkg.sv ----
// constants and state type for the second-stage entry checker
`default_nettype none
package s2c_pkg;
	// entry slice handed in covers entry bits [175:128]
	localparam int unsigned ENTRY_BASE = 128;
	localparam int unsigned ENTRY_W = 48;
	localparam int unsigned FLD_TAG_LO = 128 - ENTRY_BASE;
	localparam int unsigned FLD_SIZE_LO = 160 - ENTRY_BASE;
	localparam int unsigned FLD_LEVEL_LO = 166 - ENTRY_BASE;
	localparam int unsigned FLD_ICACHE_LO = 168 - ENTRY_BASE;
	localparam int unsigned FLD_OCACHE_LO = 170 - ENTRY_BASE;
	localparam int unsigned FLD_SHARE_LO = 172 - ENTRY_BASE;
	localparam int unsigned FLD_GRAN_LO = 174 - ENTRY_BASE;
	localparam int unsigned TAG_W = 16;
	localparam int unsigned TAG_NARROW_W = 8;
	localparam int unsigned SIZE_W = 6;
	localparam int unsigned SIZE32_W = 4;
	localparam int unsigned STAGE2_BIT = 1;
	localparam logic [1:0] STAGE_NONE = 2'h0;
	localparam logic [1:0] CACHE_NC = 2'h0;
	localparam logic [1:0] CACHE_WB_RWA = 2'h1;
	localparam logic [1:0] CACHE_WT_RA = 2'h2;
	localparam logic [1:0] CACHE_WB_RA = 2'h3;
	localparam logic [1:0] SH_NON = 2'h0;
	localparam logic [1:0] SH_RSVD = 2'h1;
	localparam logic [1:0] SH_OUTER = 2'h2;
	localparam logic [1:0] SH_INNER = 2'h3;
	localparam logic [1:0] GR_4K = 2'h0;
	localparam logic [1:0] GR_64K = 2'h1;
	localparam logic [1:0] GR_16K = 2'h2;
	localparam logic [1:0] GR_RSVD = 2'h3;
	localparam logic signed [7:0] SIZE_MAX64 = 8'h27;
	localparam logic signed [7:0] SIZE_FLOOR = 8'h10;
	localparam logic [7:0] IN_ADDR_FMT32_MIN = 8'h28;
	localparam logic signed [7:0] ADDR_BITS64 = 8'h40;
	localparam logic signed [7:0] ADDR_BITS32 = 8'h20;
	localparam int CONCAT_BITS = 4;
	localparam int DESC_BITS = 3;
	localparam int PAGE_4K = 12;
	localparam int PAGE_16K = 14;
	localparam int PAGE_64K = 16;
	localparam int LEVELS = 4;
	typedef struct packed {
		logic valid;
		logic illegal;
		logic tag_en;
		logic [15:0] tag;
		logic [7:0] size;
		logic [1:0] level;
		logic [1:0] icache;
		logic [1:0] ocache;
		logic [1:0] share;
		logic [1:0] gran;
		logic s2_en;
	} s2c_state_s;
endpackage : s2c_pkg
`default_nettype wire

// ---- rtl/s2c_level_check.sv ----
// start-level decode and input-size consistency for one entry
`default_nettype none
module s2c_level_check
	import s2c_pkg::*;
(
	input wire logic fmt64_i,
	input wire logic [1:0] gran_i,
	input wire logic signed [7:0] size_i,
	input wire logic [1:0] code_i,
	output logic [1:0] level_o,
	output logic ok_o
);
	always_comb
	begin
		int page;
		int lvl;
		int in_bits;
		int lo;
		int hi;
		logic code_ok;
		page = PAGE_4K;
		lvl = 0;
		code_ok = 1'b1;
		in_bits = 0;
		lo = 0;
		hi = 0;
		if (gran_i == GR_64K)
			page = PAGE_64K;
		else if (gran_i == GR_16K)
			page = PAGE_16K;
		// level code meaning moves with the granule
		if (!fmt64_i)
		begin
			lvl = 2 - int'(code_i);
			code_ok = !code_i[1];
		end
		else if (gran_i == GR_4K)
		begin
			lvl = 2 - int'(code_i);
			code_ok = (code_i != 2'h3);
		end
		else
		begin
			lvl = 3 - int'(code_i);
			code_ok = (code_i != 2'h3);
		end
		if (lvl < 0)
			lvl = 0;
		in_bits = fmt64_i ? int'(ADDR_BITS64) - int'(size_i) : int'(ADDR_BITS32) - int'(size_i);
		// a start table may be concatenated, widening the top of the range
		hi = page + (page - DESC_BITS) * (LEVELS - lvl) + CONCAT_BITS;
		lo = page + (page - DESC_BITS) * (LEVELS - 1 - lvl) + 1;
		level_o = 2'(lvl);
		ok_o = code_ok && (in_bits >= lo) && (in_bits <= hi);
	end
endmodule : s2c_level_check
`default_nettype wire

// ---- rtl/s2c_entry_check.sv ----
// second-stage entry field decode and legality check
`default_nettype none
// What this block does
// - No tag unless stage on, NS-EL1, present
// - Narrow tags: upper tag bits read zero
// - Wide tags use all sixteen bits
// - Tag changes need software TLB invalidation
// - Size field four or six bits by format
// - Largest 64-bit size value is 39
// - Minimum is 64 minus input address size, raised to 16 in later revision unless 64K granule
// - Input size from output size and format
// - 32-bit size value signed -8 to 7
// - First revision: illegal or clamp size
// - Later revision: out-of-range size illegal
// - Size inconsistent with level/granule is illegal
// - Fields ignored while stage two off
// - Start level decoded per granule, checked
// - Inner walk cacheability four encodings
// - Outer walk cacheability same encoding
// - Reserved shareability acts non-shareable
// - Both non-cacheable forces outer shareable
// - Granule codes 4K, 64K, 16K, reserved
// - 32-bit format forces 4K granule
// - Reserved or unsupported granule is illegal
// - Any enabled stage selects tagging
module s2c_entry_check
	import s2c_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic ENTRY_VALID_I,
	input wire logic [ENTRY_W-1:0] ENTRY_I,
	input wire logic [1:0] STAGE_SELECT_I,
	input wire logic TABLE_FORMAT_I,
	input wire logic NS_EL1_REGIME_I,
	input wire logic SECOND_STAGE_PRESENT_I,
	input wire logic WIDE_TAG_I,
	input wire logic FMT32_IMPL_I,
	input wire logic [7:0] OUTPUT_ADDR_SIZE_I,
	input wire logic [2:0] GRANULE_SUPPORT_I,
	input wire logic LATER_REV_I,
	input wire logic CLAMP_MODE_I,
	output logic VALID_O,
	output logic ILLEGAL_O,
	output logic VM_TAG_EN_O,
	output logic [TAG_W-1:0] VM_TAG_O,
	output logic [7:0] EFF_INPUT_SIZE_O,
	output logic [1:0] START_LEVEL_O,
	output logic [1:0] INNER_CACHE_O,
	output logic [1:0] OUTER_CACHE_O,
	output logic [1:0] WALK_SHARE_O,
	output logic [1:0] EFF_GRANULE_O,
	output logic STAGE2_EN_O
);
	s2c_state_s st_q;
	s2c_state_s st_d;
	logic s2_en;
	logic fmt64;
	logic [1:0] gran;
	logic [1:0] icache;
	logic [1:0] ocache;
	logic [1:0] share_raw;
	logic [TAG_W-1:0] tag_raw;
	logic [TAG_NARROW_W-1:0] tag_low;
	logic signed [7:0] raw_size;
	logic signed [7:0] min_size;
	logic signed [7:0] eff_size;
	logic [7:0] in_addr_sz;
	logic range_bad;
	logic lvl_ok;
	logic [1:0] lvl;

	assign s2_en = SECOND_STAGE_PRESENT_I && STAGE_SELECT_I[STAGE2_BIT];
	assign fmt64 = TABLE_FORMAT_I;
	assign tag_raw = ENTRY_I[FLD_TAG_LO +: TAG_W];
	assign tag_low = tag_raw[TAG_NARROW_W-1:0];
	assign icache = ENTRY_I[FLD_ICACHE_LO +: 2];
	assign ocache = ENTRY_I[FLD_OCACHE_LO +: 2];
	assign share_raw = ENTRY_I[FLD_SHARE_LO +: 2];
	// 32-bit format has only one granule
	assign gran = fmt64 ? ENTRY_I[FLD_GRAN_LO +: 2] : GR_4K;

	always_comb
	begin
		logic [SIZE_W-1:0] fld;
		fld = ENTRY_I[FLD_SIZE_LO +: SIZE_W];
		// upper two bits dropped and sign taken from bit 3 in 32-bit format
		if (fmt64)
			raw_size = {2'h0, fld};
		else
			raw_size = {{4{fld[SIZE32_W-1]}}, fld[SIZE32_W-1:0]};
		if (FMT32_IMPL_I && (OUTPUT_ADDR_SIZE_I < IN_ADDR_FMT32_MIN))
			in_addr_sz = IN_ADDR_FMT32_MIN;
		else
			in_addr_sz = OUTPUT_ADDR_SIZE_I;
		min_size = ADDR_BITS64 - $signed(in_addr_sz);
		if (LATER_REV_I && (gran != GR_64K) && (min_size < SIZE_FLOOR))
			min_size = SIZE_FLOOR;
		// every 4-bit value is in range, so only 64-bit entries can fail here
		range_bad = fmt64 && ((raw_size > SIZE_MAX64) || (raw_size < min_size));
		eff_size = raw_size;
		if (range_bad && !LATER_REV_I && CLAMP_MODE_I)
		begin
			if (raw_size > SIZE_MAX64)
				eff_size = SIZE_MAX64;
			else
				eff_size = min_size;
		end
	end

	s2c_level_check u_level (
		.fmt64_i(fmt64),
		.gran_i(gran),
		.size_i(eff_size),
		.code_i(ENTRY_I[FLD_LEVEL_LO +: 2]),
		.level_o(lvl),
		.ok_o(lvl_ok)
	);

	always_comb
	begin
		logic size_bad;
		logic gran_bad;
		size_bad = range_bad && (LATER_REV_I || !CLAMP_MODE_I);
		gran_bad = fmt64 && ((gran == GR_RSVD) || !GRANULE_SUPPORT_I[gran]);
		st_d = '0;
		st_d.valid = ENTRY_VALID_I;
		// stage 1, 2 or both on with NS-EL1 regime and stage two present tags entries
		st_d.tag_en = SECOND_STAGE_PRESENT_I && (STAGE_SELECT_I != STAGE_NONE)
			&& NS_EL1_REGIME_I;
		// tag is taken as given; no tracking of later changes, software must flush
		if (st_d.tag_en && WIDE_TAG_I)
			st_d.tag = tag_raw;
		else if (st_d.tag_en)
			st_d.tag = {8'h00, tag_raw[TAG_NARROW_W-1:0]};
		st_d.s2_en = s2_en;
		if (s2_en)
		begin
			st_d.size = eff_size;
			st_d.level = lvl;
			st_d.icache = icache;
			st_d.ocache = ocache;
			st_d.gran = gran;
			if ((icache == CACHE_NC) && (ocache == CACHE_NC))
				st_d.share = SH_OUTER;
			else if (share_raw == SH_RSVD)
				st_d.share = SH_NON;
			else
				st_d.share = share_raw;
			st_d.illegal = ENTRY_VALID_I && (size_bad || gran_bad || !lvl_ok);
		end
	end

	// size, level, cache, share and granule all held at zero while stage two off
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign VALID_O = st_q.valid;
	assign ILLEGAL_O = st_q.illegal;
	assign VM_TAG_EN_O = st_q.tag_en;
	assign VM_TAG_O = st_q.tag;
	assign EFF_INPUT_SIZE_O = st_q.size;
	assign START_LEVEL_O = st_q.level;
	assign INNER_CACHE_O = st_q.icache;
	assign OUTER_CACHE_O = st_q.ocache;
	assign WALK_SHARE_O = st_q.share;
	assign EFF_GRANULE_O = st_q.gran;
	assign STAGE2_EN_O = st_q.s2_en;

	property p_tag_off;
		@(posedge CLK_I) disable iff (RST_I)
		(!SECOND_STAGE_PRESENT_I || (STAGE_SELECT_I == STAGE_NONE) || !NS_EL1_REGIME_I)
		|=> (!VM_TAG_EN_O && (VM_TAG_O == 16'h0000));
	endproperty
	a_tag_off: assert property (p_tag_off) else $error("tag used while tagging off");

	property p_tag_wide;
		@(posedge CLK_I) disable iff (RST_I)
		(SECOND_STAGE_PRESENT_I && STAGE_SELECT_I[0] && NS_EL1_REGIME_I && WIDE_TAG_I)
		|=> (VM_TAG_EN_O && (VM_TAG_O == $past(tag_raw)));
	endproperty
	a_tag_wide: assert property (p_tag_wide) else $error("wide tag not carried whole");

	property p_tag_narrow;
		@(posedge CLK_I) disable iff (RST_I)
		!WIDE_TAG_I |=> (VM_TAG_O[15:8] == 8'h00);
	endproperty
	a_tag_narrow: assert property (p_tag_narrow) else $error("narrow tag upper bits set");

	property p_size_max;
		@(posedge CLK_I) disable iff (RST_I)
		(ENTRY_VALID_I && s2_en && fmt64 && LATER_REV_I && (raw_size > SIZE_MAX64))
		|=> ILLEGAL_O;
	endproperty
	a_size_max: assert property (p_size_max) else $error("oversize input not illegal");

	property p_clamp;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && fmt64 && !LATER_REV_I && CLAMP_MODE_I && (raw_size > SIZE_MAX64))
		|=> (EFF_INPUT_SIZE_O == 8'h27);
	endproperty
	a_clamp: assert property (p_clamp) else $error("oversize input not clamped to 39");

	property p_share_nc;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && (icache == CACHE_NC) && (ocache == CACHE_NC)) |=> (WALK_SHARE_O == SH_OUTER);
	endproperty
	a_share_nc: assert property (p_share_nc) else $error("non-cacheable walk not outer");

	property p_share_rsvd;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && (share_raw == SH_RSVD) && ((icache != CACHE_NC) || (ocache != CACHE_NC)))
		|=> (WALK_SHARE_O == SH_NON);
	endproperty
	a_share_rsvd: assert property (p_share_rsvd) else $error("reserved share not non");

	property p_gran32;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && !fmt64) |=> (EFF_GRANULE_O == GR_4K);
	endproperty
	a_gran32: assert property (p_gran32) else $error("32-bit format granule not 4K");

	property p_gran_rsvd;
		@(posedge CLK_I) disable iff (RST_I)
		(ENTRY_VALID_I && s2_en && fmt64 && (ENTRY_I[FLD_GRAN_LO +: 2] == GR_RSVD))
		|=> ILLEGAL_O;
	endproperty
	a_gran_rsvd: assert property (p_gran_rsvd) else $error("reserved granule not illegal");

	property p_s2_off;
		@(posedge CLK_I) disable iff (RST_I)
		!s2_en |=> (!ILLEGAL_O && (EFF_INPUT_SIZE_O == 8'h00) && (WALK_SHARE_O == SH_NON));
	endproperty
	a_s2_off: assert property (p_s2_off) else $error("fields used with stage two off");

	property p_flag_one_cycle;
		@(posedge CLK_I) disable iff (RST_I)
		!ENTRY_VALID_I |=> (!VALID_O && !ILLEGAL_O);
	endproperty
	a_flag_one_cycle: assert property (p_flag_one_cycle) else $error("result without entry");

	property p_valid_follow;
		@(posedge CLK_I) disable iff (RST_I)
		ENTRY_VALID_I |=> VALID_O;
	endproperty
	a_valid_follow: assert property (p_valid_follow) else $error("entry result missing");

	property p_tag_low;
		@(posedge CLK_I) disable iff (RST_I)
		(SECOND_STAGE_PRESENT_I && (STAGE_SELECT_I != STAGE_NONE) && NS_EL1_REGIME_I
			&& !WIDE_TAG_I)
		|=> (VM_TAG_EN_O && (VM_TAG_O[TAG_NARROW_W-1:0] == $past(tag_low)));
	endproperty
	a_tag_low: assert property (p_tag_low) else $error("narrow tag low byte lost");

	property p_tag_s2_only;
		@(posedge CLK_I) disable iff (RST_I)
		(SECOND_STAGE_PRESENT_I && NS_EL1_REGIME_I && (STAGE_SELECT_I == 2'h2)) |=> VM_TAG_EN_O;
	endproperty
	a_tag_s2_only: assert property (p_tag_s2_only) else $error("stage two alone untagged");

	property p_size_min;
		@(posedge CLK_I) disable iff (RST_I)
		(ENTRY_VALID_I && s2_en && fmt64 && LATER_REV_I && (raw_size < min_size))
		|=> ILLEGAL_O;
	endproperty
	a_size_min: assert property (p_size_min) else $error("undersize input not illegal");

	property p_clamp_min;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && fmt64 && !LATER_REV_I && CLAMP_MODE_I && (raw_size < min_size))
		|=> (EFF_INPUT_SIZE_O == $past(min_size));
	endproperty
	a_clamp_min: assert property (p_clamp_min) else $error("undersize input not clamped");

	// 32-bit sizes are sign-extended from four bits, so the top five bits agree
	property p_fmt32_size;
		@(posedge CLK_I) disable iff (RST_I)
		(s2_en && !fmt64)
		|=> ((EFF_INPUT_SIZE_O[7:3] == 5'h00) || (EFF_INPUT_SIZE_O[7:3] == 5'h1F));
	endproperty
	a_fmt32_size: assert property (p_fmt32_size) else $error("32-bit size out of -8..7");

	property p_level_bad;
		@(posedge CLK_I) disable iff (RST_I)
		(ENTRY_VALID_I && s2_en && !lvl_ok) |=> ILLEGAL_O;
	endproperty
	a_level_bad: assert property (p_level_bad) else $error("bad start level not illegal");

	property p_gran_unsup;
		@(posedge CLK_I) disable iff (RST_I)
		(ENTRY_VALID_I && s2_en && fmt64 && (gran != GR_RSVD) && !GRANULE_SUPPORT_I[gran])
		|=> ILLEGAL_O;
	endproperty
	a_gran_unsup: assert property (p_gran_unsup) else $error("unsupported granule legal");

	property p_share_legal;
		@(posedge CLK_I) disable iff (RST_I)
		ENTRY_VALID_I |=> (WALK_SHARE_O != SH_RSVD);
	endproperty
	a_share_legal: assert property (p_share_legal) else $error("reserved share shown");

	property p_cache_pass;
		@(posedge CLK_I) disable iff (RST_I)
		s2_en |=> ((INNER_CACHE_O == $past(icache)) && (OUTER_CACHE_O == $past(ocache)));
	endproperty
	a_cache_pass: assert property (p_cache_pass) else $error("walk cacheability altered");
endmodule : s2c_entry_check
`default_nettype wire

// ---- test/s2c_entry_writer.sv ----
// hypervisor-side model that lays second-stage fields into an entry
`default_nettype none
module s2c_entry_writer
	import s2c_pkg::*;
(
	input wire logic clk_i,
	input wire logic post_i,
	input wire logic [15:0] tag_i,
	input wire logic [5:0] size_i,
	input wire logic [1:0] level_i,
	input wire logic [1:0] icache_i,
	input wire logic [1:0] ocache_i,
	input wire logic [1:0] share_i,
	input wire logic [1:0] gran_i,
	output logic valid_o,
	output logic [ENTRY_W-1:0] entry_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ENTRY_W-1:0] cur;
	logic [ENTRY_W-1:0] last_q = '0;
	// software keeps write-back walks when table updates are on
	// a tag rewrite is followed by its own invalidation, not modelled here
	assign cur = {gran_i, share_i, ocache_i, icache_i, level_i, size_i, 16'h0000, tag_i};
	// no stale entry left on the lines while idle: show its inverse
	assign entry_o = post_i ? cur : ~last_q;
	assign valid_o = post_i;
	always_ff @(posedge clk_i)
	begin
		if (post_i)
			last_q <= cur;
	end
endmodule : s2c_entry_writer
`default_nettype wire

// ---- test/s2c_entry_check_tb.sv ----
// self-checking bench for the second-stage entry checker
`default_nettype none
module s2c_entry_check_tb
	import s2c_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic post = 1'b0;
	logic [15:0] tag = 16'hA5C3;
	logic [5:0] size = '0;
	logic [1:0] lvl = '0, ic = '0, oc = '0, sh = '0, gr = '0, sel = 2'h3;
	logic fmt = 1'b1, ns = 1'b1, pres = 1'b1, wide = 1'b1, impl = 1'b1;
	logic later = 1'b1, clamp = 1'b0, evalid, valid, ill, ten, s2en;
	logic [7:0] out_sz = 8'h30;
	logic [2:0] gsup = 3'h7;
	logic [ENTRY_W-1:0] entry;
	logic [15:0] vtag;
	logic [7:0] esz;
	logic [1:0] slv, icq, ocq, shq, egr;
	int fails = 0, check_count = 0, cycles = 0;
	always #4 clk = ~clk;
	s2c_entry_writer u_s2c_entry_writer (.clk_i(clk), .post_i(post), .tag_i(tag),
		.size_i(size), .level_i(lvl), .icache_i(ic), .ocache_i(oc), .share_i(sh),
		.gran_i(gr), .valid_o(evalid), .entry_o(entry));
	s2c_entry_check u_s2c_entry_check (.CLK_I(clk), .RST_I(rst), .ENTRY_VALID_I(evalid),
		.ENTRY_I(entry), .STAGE_SELECT_I(sel), .TABLE_FORMAT_I(fmt), .NS_EL1_REGIME_I(ns),
		.SECOND_STAGE_PRESENT_I(pres), .WIDE_TAG_I(wide), .FMT32_IMPL_I(impl),
		.OUTPUT_ADDR_SIZE_I(out_sz), .GRANULE_SUPPORT_I(gsup), .LATER_REV_I(later),
		.CLAMP_MODE_I(clamp), .VALID_O(valid), .ILLEGAL_O(ill), .VM_TAG_EN_O(ten),
		.VM_TAG_O(vtag), .EFF_INPUT_SIZE_O(esz), .START_LEVEL_O(slv), .INNER_CACHE_O(icq),
		.OUTER_CACHE_O(ocq), .WALK_SHARE_O(shq), .EFF_GRANULE_O(egr), .STAGE2_EN_O(s2en));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	// entry launched at the falling edge, result read at the following fall
	task automatic send(input logic [5:0] s, input logic [1:0] l, input logic [1:0] g);
		@(negedge clk);
		post = 1'b1;
		size = s;
		lvl = l;
		gr = g;
		@(posedge clk);
		@(negedge clk);
	endtask : send
	// size, level and granule only mean something on a legal entry
	task automatic expect_out(input logic il, input logic [7:0] sz, input logic [1:0] l,
		input logic [1:0] g);
		check("valid", 16'(valid), 16'h0001);
		check("illegal", 16'(ill), 16'(il));
		if (!il)
		begin
			check("size", 16'(esz), 16'(sz));
			check("level", 16'(slv), 16'(l));
			check("granule", 16'(egr), 16'(g));
		end
	endtask : expect_out
	task automatic t_tag();
		logic en;
		for (int i = 0; i < 16; i++)
		begin
			sel = i[1:0];
			ns = i[2];
			wide = i[3];
			send(6'h19, 2'h1, 2'h0);
			en = (sel != 2'h0) && ns;
			check("tag_en", 16'(ten), 16'(en));
			check("tag", vtag, en ? (wide ? tag : 16'h00C3) : 16'h0000);
		end
	endtask : t_tag
	task automatic t_cache();
		logic [1:0] esh;
		for (int i = 0; i < 64; i++)
		begin
			ic = i[1:0];
			oc = i[3:2];
			sh = i[5:4];
			send(6'h19, 2'h1, 2'h0);
			esh = (ic == 2'h0 && oc == 2'h0) ? SH_OUTER : (sh == SH_RSVD ? SH_NON : sh);
			check("inner", 16'(icq), 16'(ic));
			check("outer", 16'(ocq), 16'(oc));
			check("share", 16'(shq), 16'(esh));
			check("stage2_on", 16'(s2en), 16'h0001);
			expect_out(1'b0, 8'h19, 2'h1, 2'h0);
		end
	endtask : t_cache
	task automatic t_gran();
		gsup = 3'h5;
		for (int g = 0; g < 4; g++)
		begin
			send(6'h19, 2'h1, 2'(g));
			expect_out(g == 1 || g == 3, 8'h19, g == 0 ? 2'h1 : 2'h2, 2'(g));
		end
		gsup = 3'h7;
		send(6'h19, 2'h1, 2'h1);
		expect_out(1'b0, 8'h19, 2'h2, 2'h1);
		fmt = 1'b0;
		send(6'h30, 2'h1, 2'h1);
		expect_out(1'b0, 8'h00, 2'h1, 2'h0);
		send(6'h08, 2'h1, 2'h0);
		expect_out(1'b0, 8'hF8, 2'h1, 2'h0);
		send(6'h07, 2'h1, 2'h0);
		expect_out(1'b1, 8'h07, 2'h1, 2'h0);
		send(6'h07, 2'h0, 2'h0);
		expect_out(1'b0, 8'h07, 2'h2, 2'h0);
		send(6'h07, 2'h2, 2'h0);
		expect_out(1'b1, 8'h07, 2'h0, 2'h0);
		fmt = 1'b1;
	endtask : t_gran
	task automatic t_size();
		out_sz = 8'h24;
		send(6'h18, 2'h1, 2'h0);
		expect_out(1'b0, 8'h18, 2'h1, 2'h0);
		send(6'h17, 2'h1, 2'h0);
		expect_out(1'b1, 8'h17, 2'h1, 2'h0);
		impl = 1'b0;
		send(6'h18, 2'h1, 2'h0);
		expect_out(1'b1, 8'h18, 2'h1, 2'h0);
		out_sz = 8'h34;
		send(6'h0F, 2'h2, 2'h0);
		expect_out(1'b1, 8'h0F, 2'h0, 2'h0);
		send(6'h0F, 2'h2, 2'h1);
		expect_out(1'b0, 8'h0F, 2'h1, 2'h1);
		send(6'h27, 2'h0, 2'h0);
		expect_out(1'b0, 8'h27, 2'h2, 2'h0);
		send(6'h19, 2'h0, 2'h0);
		expect_out(1'b1, 8'h19, 2'h2, 2'h0);
		send(6'h19, 2'h3, 2'h0);
		expect_out(1'b1, 8'h19, 2'h0, 2'h0);
		later = 1'b0;
		send(6'h0F, 2'h2, 2'h0);
		expect_out(1'b0, 8'h0F, 2'h0, 2'h0);
		send(6'h28, 2'h0, 2'h0);
		expect_out(1'b1, 8'h28, 2'h2, 2'h0);
		clamp = 1'b1;
		send(6'h28, 2'h0, 2'h0);
		expect_out(1'b0, 8'h27, 2'h2, 2'h0);
		send(6'h0B, 2'h2, 2'h0);
		expect_out(1'b0, 8'h0C, 2'h0, 2'h0);
		later = 1'b1;
		send(6'h28, 2'h0, 2'h0);
		expect_out(1'b1, 8'h28, 2'h2, 2'h0);
	endtask : t_size
	// mid-run reset clears every result, then the next entry decodes normally
	task automatic t_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check("rst_flags", 16'({valid, ill, ten, s2en, esz, slv}), 16'h0000);
		check("rst_walk", 16'({icq, ocq, shq, egr}), 16'h0000);
		check("rst_tag", vtag, 16'h0000);
		rst = 1'b0;
		send(6'h19, 2'h1, 2'h0);
		check("rst_share", 16'(shq), 16'(SH_INNER));
		expect_out(1'b0, 8'h19, 2'h1, 2'h0);
	endtask : t_reset
	task automatic t_off();
		for (int i = 0; i < 2; i++)
		begin
			sel = i ? 2'h3 : 2'h1;
			pres = i[0] ? 1'b0 : 1'b1;
			send(6'h3F, 2'h3, 2'h3);
			check("stage2", 16'(s2en), 16'h0000);
			check("off_ill", 16'(ill), 16'h0000);
			check("off_size", 16'({esz, slv, icq, egr}), 16'h0000);
			check("off_walk", 16'({ocq, shq}), 16'h0000);
			check("off_tag", 16'(ten), 16'(i == 0));
		end
		@(negedge clk);
		post = 1'b0;
		@(posedge clk);
		@(negedge clk);
		check("idle", 16'({valid, ill}), 16'h0000);
	endtask : t_off
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_tag();
		t_cache();
		t_gran();
		t_size();
		t_reset();
		t_off();
		summarize();
	end
endmodule : s2c_entry_check_tb
`default_nettype wire
